// File: sbb_buffer_ctrl.sv
// Sensor batch buffer control: staging FIFO and top level
`timescale 1ns/100ps
`default_nettype none
`include "sbb_regs.svh"

//--------------------------------------------------
// Staging FIFO between set sequencer and storage
//--------------------------------------------------
module sbb_stage_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Control
	input  wire logic         flush,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] DC = (AW+1)'(D);
	logic [W-1:0]  mem [0:D-1];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;
	assign in_ready  = (cnt != DC);
	assign out_valid = (cnt != '0);
	assign out_data  = mem[rp];
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else if (flush) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push)
				wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
			cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wp] <= in_data;
	end
endmodule

//--------------------------------------------------
// Batch buffer control top
//--------------------------------------------------
module sbb_buffer_ctrl #(
	parameter int STAGE_DEPTH = 8
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_b,
	// Register port
	input  wire logic [6:0]          reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	output logic                     reg_rvalid,
	// Sensor side pins and sample data
	input  wire logic                drdy_pin,
	input  wire logic                step_pin,
	input  wire logic                trig_pin,
	input  wire sbb_pkg::sbb_sample_s sample,
	// Loose control bits
	input  wire logic                limit_depth_to_watermark,
	input  wire logic                pin1_watermark_route,
	input  wire logic                pin1_overwrite_route,
	input  wire logic                pin1_filled_route,
	input  wire logic                pin2_watermark_route,
	input  wire logic                pin2_overwrite_route,
	input  wire logic                pin2_filled_route,
	// Interrupt pins
	output logic                     int1_pin,
	output logic                     int2_pin
);
	import sbb_pkg::*;

	logic [2:0]  sync1;
	logic [2:0]  sync2;
	logic [2:0]  sync3;
	logic [7:0]  thr_lo;
	logic [7:0]  thr_hi;
	logic [7:0]  dec_cfg;
	logic [7:0]  dec3_cfg;
	logic [7:0]  rate_cfg;
	logic        sw_done;
	sbb_op_e     op;
	logic [2:0]  dsel [3];
	logic [5:0]  dcnt [3];
	logic [2:0]  due;
	logic [15:0] words [9];
	logic [15:0] next_words [9];
	logic [8:0]  pend;
	logic [8:0]  next_mask;
	logic [3:0]  idx;
	logic        st_ready;
	logic        drain_rdy;
	logic        sv;
	logic [15:0] sd;
	logic [15:0] mem [0:4095];
	logic [11:0] wp;
	logic [11:0] rp;
	logic [12:0] level;
	logic        ovr;
	sbb_flags_s  fl;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	//--------------------------------------------------
	// Pin synchronisers and edge detect
	//--------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
		end else begin
			sync1 <= {trig_pin, step_pin, drdy_pin};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	wire drdy_rise = sync2[0] && !sync3[0];
	wire step_rise = sync2[1] && !sync3[1];
	wire trig_hi   = sync2[2];

	//--------------------------------------------------
	// Configuration registers
	//--------------------------------------------------
	wire wr_thr_lo = reg_wr && (reg_addr == `SBB_A_THR_LO);
	wire wr_thr_hi = reg_wr && (reg_addr == `SBB_A_THR_HI);
	wire wr_dec    = reg_wr && (reg_addr == `SBB_A_DEC);
	wire wr_dec3   = reg_wr && (reg_addr == `SBB_A_DEC3);
	wire wr_rate   = reg_wr && (reg_addr == `SBB_A_RATE);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			thr_lo   <= `SBB_RST_CFG;
			thr_hi   <= `SBB_RST_CFG;
			dec_cfg  <= `SBB_RST_CFG;
			dec3_cfg <= `SBB_RST_CFG;
			rate_cfg <= `SBB_RST_CFG;
		end else begin
			if (wr_thr_lo)
				thr_lo <= reg_wdata;
			if (wr_thr_hi)
				thr_hi <= reg_wdata & `SBB_M_THR_HI;
			if (wr_dec)
				dec_cfg <= reg_wdata & `SBB_M_DEC;
			if (wr_dec3)
				dec3_cfg <= reg_wdata & `SBB_M_DEC3;
			if (wr_rate)
				rate_cfg <= reg_wdata & `SBB_M_RATE;
		end
	end
	wire        third_set_store_enable   = thr_hi[`SBB_B_THIRD_EN];
	wire        step_triggered_store     = thr_hi[`SBB_B_STEP_TRIG];
	wire [3:0]  watermark_level_high     = thr_hi[3:0];
	wire [7:0]  watermark_level_low      = thr_lo;
	wire [2:0]  gyro_decimation_sel      = dec_cfg[5:3];
	wire [2:0]  accel_decimation_sel     = dec_cfg[2:0];
	wire [2:0]  third_set_decimation_sel = dec3_cfg[5:3];
	wire        high_only                = dec3_cfg[`SBB_B_HIGH_ONLY];
	wire [3:0]  buffer_rate_sel          = rate_cfg[6:3];
	wire [2:0]  mode_sel                 = rate_cfg[2:0];
	wire [11:0] wm = {watermark_level_high, watermark_level_low};

	//--------------------------------------------------
	// Operating mode
	//--------------------------------------------------
	// Trigger release is latched until the mode is rewritten
	wire sw_arm = (mode_sel == `SBB_MODE_C2F) || (mode_sel == `SBB_MODE_B2C);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			sw_done <= 1'b0;
		else
			sw_done <= (sw_arm && !trig_hi) || (sw_done && !wr_rate);
	end
	always_comb begin
		case (mode_sel)
			`SBB_MODE_STOP: op = SBB_OP_STOP;
			`SBB_MODE_CONT: op = SBB_OP_CONT;
			`SBB_MODE_C2F:  op = sw_done ? SBB_OP_STOP : SBB_OP_CONT;
			`SBB_MODE_B2C:  op = sw_done ? SBB_OP_CONT : SBB_OP_BYPASS;
			default:        op = SBB_OP_BYPASS;
		endcase
	end
	wire bypass  = (op == SBB_OP_BYPASS);
	wire rate_ok = (buffer_rate_sel != 4'h0) && (buffer_rate_sel <= `SBB_RATE_MAX);
	wire trig_ev = step_triggered_store ? step_rise : drdy_rise;
	wire store_evt = trig_ev && rate_ok && !bypass && (pend == 9'h000);

	//--------------------------------------------------
	// Decimation per data set
	//--------------------------------------------------
	function automatic logic [5:0] fact(input logic [2:0] c);
		case (c)
			3'h2:    fact = 6'h02;
			3'h3:    fact = 6'h03;
			3'h4:    fact = 6'h04;
			3'h5:    fact = 6'h08;
			3'h6:    fact = 6'h10;
			3'h7:    fact = 6'h20;
			default: fact = 6'h01;
		endcase
	endfunction
	assign dsel[0] = gyro_decimation_sel;
	assign dsel[1] = accel_decimation_sel;
	assign dsel[2] = third_set_decimation_sel;
	for (genvar g = 0; g < 3; g++) begin : g_dec
		assign due[g] = (dsel[g] != 3'h0) && (dcnt[g] == 6'h00);
		always_ff @(posedge clk_sys or negedge rst_b) begin
			if (!rst_b)
				dcnt[g] <= 6'h00;
			else if (bypass)
				dcnt[g] <= 6'h00;
			else if (store_evt && dsel[g] != 3'h0)
				dcnt[g] <= due[g] ? fact(dsel[g]) - 6'h01 : dcnt[g] - 6'h01;
		end
	end

	//--------------------------------------------------
	// Set sequencer
	//--------------------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_words[i]   = sample.gyro[i];
			next_words[i+3] = sample.accel[i];
			next_words[i+6] = sample.third[i];
		end
		next_mask = {{3{due[2] && third_set_store_enable}}, {3{due[1]}}, {3{due[0]}}};
		if (high_only) begin
			next_words[0] = {sample.gyro[0][15:8], sample.gyro[1][15:8]};
			next_words[1] = {sample.gyro[2][15:8], sample.accel[0][15:8]};
			next_words[2] = {sample.accel[1][15:8], sample.accel[2][15:8]};
			next_mask[5:0] = {3'h0, {3{due[0] || due[1]}}};
		end
	end
	always_comb begin
		idx = 4'h0;
		for (int i = 8; i >= 0; i--) begin
			if (pend[i])
				idx = 4'(i);
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			pend <= 9'h000;
		else if (bypass)
			pend <= 9'h000;
		else if (store_evt)
			pend <= next_mask;
		else if (st_ready && pend != 9'h000)
			pend[idx] <= 1'b0;
	end
	always_ff @(posedge clk_sys) begin
		if (store_evt)
			words <= next_words;
	end

	sbb_stage_fifo #(
		.W (16),
		.D (STAGE_DEPTH)
	) u_stage (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.flush     (bypass),
		.in_valid  (pend != 9'h000),
		.in_ready  (st_ready),
		.in_data   (words[idx]),
		.out_valid (sv),
		.out_ready (drain_rdy),
		.out_data  (sd)
	);

	//--------------------------------------------------
	// Word storage and level
	//--------------------------------------------------
	wire [12:0] cap = (limit_depth_to_watermark && wm != 12'h000) ? {1'b0, wm} : `SBB_DEPTH;
	wire        is_full = (level >= cap);
	wire        pop_req = reg_rd && (reg_addr == `SBB_A_OUT_H) && (level != 13'h0000);
	// Storage has one port: a popping read of the high output byte stalls the drain for a cycle
	assign drain_rdy = !pop_req;
	wire        acc = sv && drain_rdy;
	wire        wr_new = acc && !bypass && !is_full;
	wire        wr_over = acc && (op == SBB_OP_CONT) && is_full;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wp    <= 12'h000;
			rp    <= 12'h000;
			level <= 13'h0000;
		end else if (bypass) begin
			wp    <= 12'h000;
			rp    <= 12'h000;
			level <= 13'h0000;
		end else begin
			if (wr_new || wr_over)
				wp <= wp + 12'h001;
			if (wr_over || pop_req)
				rp <= rp + 12'h001;
			if (wr_new)
				level <= level + 13'h0001;
			else if (pop_req)
				level <= level - 13'h0001;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (wr_new || wr_over)
			mem[wp] <= sd;
	end
	wire [15:0] head = mem[rp];

	//--------------------------------------------------
	// Status flags
	//--------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			ovr <= 1'b0;
		else
			ovr <= wr_over || (ovr && !(pop_req || bypass));
	end
	assign fl.empty = (level == 13'h0000);
	assign fl.full  = is_full;
	assign fl.ovr   = ovr;
	assign fl.wm    = !fl.empty && (level >= {1'b0, wm});
	wire [11:0] unread_word_count = fl.full ? 12'h000 : level[11:0];
	logic [7:0] st2;
	always_comb begin
		st2              = {4'h0, unread_word_count[11:8]};
		st2[`SBB_B_WM]    = fl.wm;
		st2[`SBB_B_OVR]   = fl.ovr;
		st2[`SBB_B_FULL]  = fl.full;
		st2[`SBB_B_EMPTY] = fl.empty;
	end

	//--------------------------------------------------
	// Register read and interrupt pins
	//--------------------------------------------------
	wire [7:0] rd_mux =
		(reg_addr == `SBB_A_THR_LO) ? thr_lo :
		(reg_addr == `SBB_A_THR_HI) ? thr_hi :
		(reg_addr == `SBB_A_DEC)    ? dec_cfg :
		(reg_addr == `SBB_A_DEC3)   ? dec3_cfg :
		(reg_addr == `SBB_A_RATE)   ? rate_cfg :
		(reg_addr == `SBB_A_ST1)    ? unread_word_count[7:0] :
		(reg_addr == `SBB_A_ST2)    ? st2 :
		(reg_addr == `SBB_A_OUT_L)  ? head[7:0] :
		(reg_addr == `SBB_A_OUT_H)  ? head[15:8] : 8'h00;
	wire next_int1 = (pin1_watermark_route && fl.wm) || (pin1_overwrite_route && fl.ovr) ||
		(pin1_filled_route && fl.full);
	wire next_int2 = (pin2_watermark_route && fl.wm) || (pin2_overwrite_route && fl.ovr) ||
		(pin2_filled_route && fl.full);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
			int1_pin   <= 1'b0;
			int2_pin   <= 1'b0;
		end else begin
			if (reg_rd)
				reg_rdata <= rd_mux;
			reg_rvalid <= reg_rd;
			int1_pin   <= next_int1;
			int2_pin   <= next_int2;
		end
	end

	//--------------------------------------------------
	// Assertions
	//--------------------------------------------------
	sequence s_store;
		store_evt ##1 (pend != 9'h000);
	endsequence
	bypass_clear_a: assert property (bypass |=> level == 13'h0000)
		else $error("bypass did not empty the buffer");
	full_count_a: assert property (fl.full |-> st2[3:0] == 4'h0 && unread_word_count == 12'h000)
		else $error("unread count not zero while full");
	over_flag_a: assert property (wr_over |=> ovr && level == $past(level))
		else $error("overwrite did not raise overrun");
	stop_hold_a: assert property (acc && is_full && op == SBB_OP_STOP |=> wp == $past(wp))
		else $error("stop mode wrote into a full buffer");
	count_step_a: assert property (wr_new |=> level == $past(level) + 13'h0001)
		else $error("level did not follow a write");
	wm_flag_a: assert property ($rose(fl.wm) |-> level >= {1'b0, wm} && level != 13'h0000)
		else $error("watermark flag rose below watermark");
	pin_route_a: assert property (pin1_filled_route && fl.full |=> int1_pin)
		else $error("full flag not routed to pin one");
	step_trig_a: assert property (store_evt && step_triggered_store |-> step_rise)
		else $error("store without step in step mode");
	third_gate_a: assert property (store_evt && !third_set_store_enable |=> pend[8:6] == 3'h0)
		else $error("third set stored while disabled");
	gyro_off_a: assert property (store_evt && gyro_decimation_sel == 3'h0 && !high_only
		|=> pend[2:0] == 3'h0)
		else $error("gyro set stored while excluded");
	store_seq_a: assert property (store_evt && next_mask != 9'h000 |-> s_store)
		else $error("store event left nothing pending");
	rate_off_a: assert property (buffer_rate_sel == 4'h0 |-> !store_evt)
		else $error("store while rate disabled");
endmodule
`default_nettype wire

// File: sbb_regs.svh
// Register offsets, field positions, masks and reset values of the batch buffer
`ifndef SBB_REGS_SVH
`define SBB_REGS_SVH
`define SBB_A_THR_LO    7'h06
`define SBB_A_THR_HI    7'h07
`define SBB_A_DEC       7'h08
`define SBB_A_DEC3      7'h09
`define SBB_A_RATE      7'h0a
`define SBB_A_ST1       7'h3a
`define SBB_A_ST2       7'h3b
`define SBB_A_OUT_L     7'h3e
`define SBB_A_OUT_H     7'h3f
`define SBB_M_THR_HI    8'hcf
`define SBB_M_DEC       8'h3f
`define SBB_M_DEC3      8'h7f
`define SBB_M_RATE      8'h7f
`define SBB_RST_CFG     8'h00
`define SBB_B_THIRD_EN  7
`define SBB_B_STEP_TRIG 6
`define SBB_B_HIGH_ONLY 6
`define SBB_B_WM        7
`define SBB_B_OVR       6
`define SBB_B_FULL      5
`define SBB_B_EMPTY     4
`define SBB_RATE_MAX    4'ha
`define SBB_DEPTH       13'h1000
`define SBB_MODE_BYP    3'h0
`define SBB_MODE_STOP   3'h1
`define SBB_MODE_C2F    3'h3
`define SBB_MODE_B2C    3'h4
`define SBB_MODE_CONT   3'h6
`endif

// File: sbb_pkg.sv
// Types shared by the batch buffer control
`default_nettype none
package sbb_pkg;
	typedef enum logic [1:0] {
		SBB_OP_BYPASS,
		SBB_OP_STOP,
		SBB_OP_CONT
	} sbb_op_e;
	typedef struct packed {
		logic [2:0][15:0] gyro;
		logic [2:0][15:0] accel;
		logic [2:0][15:0] third;
	} sbb_sample_s;
	typedef struct packed {
		logic wm;
		logic ovr;
		logic full;
		logic empty;
	} sbb_flags_s;
endpackage
`default_nettype wire

// File: sbb_unused_guard.sv
// (intentionally no content beyond guard)
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: sbb_sensor_model.sv
// Behavioural model of the sensor side feeding the batch buffer
`timescale 1ns/100ps
`default_nettype none

module sbb_sensor_model (
	// Clock
	input  wire logic          clk_sys,
	// Event and trigger pins
	output logic               drdy_pin,
	output logic               step_pin,
	output logic               trig_pin,
	// Sample words
	output var sbb_pkg::sbb_sample_s sample
);
	import sbb_pkg::*;

	initial begin
		drdy_pin = 1'b0;
		step_pin = 1'b0;
		trig_pin = 1'b0;
		sample   = '0;
	end

	//--------------------------------------------------
	// One store event: gyro words k0..2, accel k3..5, third k6..8
	//--------------------------------------------------
	task automatic fire(input logic use_step, input logic [15:0] base);
		int k;
		@(posedge clk_sys);
		for (k = 0; k < 3; k++) begin
			sample.gyro[k]  <= base + 16'(k) * 16'h0101;
			sample.accel[k] <= base + 16'(k + 3) * 16'h0101;
			sample.third[k] <= base + 16'(k + 6) * 16'h0101;
		end
		drdy_pin <= !use_step;
		step_pin <= use_step;
		repeat (4) @(posedge clk_sys);
		drdy_pin <= 1'b0;
		step_pin <= 1'b0;
		// Hold time over: words no longer valid
		sample   <= ~sample;
		repeat (14) @(posedge clk_sys);
	endtask

	task automatic set_trig(input logic lvl);
		@(posedge clk_sys);
		trig_pin <= lvl;
	endtask
endmodule

`default_nettype wire

// File: sbb_buffer_ctrl_test.sv
// Self-checking testbench of the batch buffer control
`timescale 1ns/100ps
`default_nettype none

`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end

module sbb_buffer_ctrl_test;
	import sbb_pkg::*;

	logic        clk_sys;
	logic        rst_b;
	logic [6:0]  reg_addr;
	logic        reg_wr;
	logic [7:0]  reg_wdata;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	wire logic   drdy_pin;
	wire logic   step_pin;
	wire logic   trig_pin;
	sbb_sample_s sample;
	logic        limit_depth_to_watermark;
	logic        pin1_watermark_route;
	logic        pin1_overwrite_route;
	logic        pin1_filled_route;
	logic        pin2_watermark_route;
	logic        pin2_overwrite_route;
	logic        pin2_filled_route;
	logic        int1_pin;
	logic        int2_pin;
	int          error_cnt;
	int          tests_run;
	int          cycles;
	int          fac[8] = '{0, 1, 2, 3, 4, 8, 16, 32};
	logic [6:0]  m_addr[5] = '{7'h06, 7'h07, 7'h08, 7'h09, 7'h0a};
	logic [7:0]  m_val[5]  = '{8'hff, 8'hcf, 8'h3f, 8'h7f, 8'h7f};
	logic [7:0]  off_cfg[5] = '{8'h01, 8'h59, 8'h0a, 8'h0d, 8'h0f};

	sbb_buffer_ctrl dut (
		.clk_sys                  (clk_sys),
		.rst_b                    (rst_b),
		.reg_addr                 (reg_addr),
		.reg_wr                   (reg_wr),
		.reg_wdata                (reg_wdata),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.reg_rvalid               (reg_rvalid),
		.drdy_pin                 (drdy_pin),
		.step_pin                 (step_pin),
		.trig_pin                 (trig_pin),
		.sample                   (sample),
		.limit_depth_to_watermark (limit_depth_to_watermark),
		.pin1_watermark_route     (pin1_watermark_route),
		.pin1_overwrite_route     (pin1_overwrite_route),
		.pin1_filled_route        (pin1_filled_route),
		.pin2_watermark_route     (pin2_watermark_route),
		.pin2_overwrite_route     (pin2_overwrite_route),
		.pin2_filled_route        (pin2_filled_route),
		.int1_pin                 (int1_pin),
		.int2_pin                 (int2_pin)
	);

	sbb_sensor_model model (
		.clk_sys  (clk_sys),
		.drdy_pin (drdy_pin),
		.step_pin (step_pin),
		.trig_pin (trig_pin),
		.sample   (sample)
	);

	//--------------------------------------------------
	// Clock, reset values and hang guard
	//--------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		rst_b = 1'b0;
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_wdata = '0;
		reg_rd = 1'b0;
		limit_depth_to_watermark = 1'b0;
		pin1_watermark_route = 1'b0;
		pin1_overwrite_route = 1'b0;
		pin1_filled_route = 1'b1;
		pin2_watermark_route = 1'b0;
		pin2_overwrite_route = 1'b1;
		pin2_filled_route = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		cycles = 0;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end

	//--------------------------------------------------
	// Register access and helpers
	//--------------------------------------------------
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		d = reg_rdata;
	endtask

	task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	// Low byte first, high byte read pops the word
	task automatic pop_chk(input logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(7'h3e, lo);
		rd(7'h3f, hi);
		`CHK({hi, lo}, e)
	endtask

	function automatic logic [15:0] wv(input logic [15:0] b, input int k);
		return b + 16'(k) * 16'h0101;
	endfunction

	function automatic logic [7:0] hb(input logic [15:0] b, input int k);
		logic [15:0] w;
		w = b + 16'(k) * 16'h0101;
		return w[15:8];
	endfunction

	// Bypass with rate 1 empties buffer and decimation counters
	task automatic clear_buf();
		wr(7'h0a, 8'h08);
		wr(7'h07, 8'h00);
		wr(7'h09, 8'h00);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	//--------------------------------------------------
	// Test sequence
	//--------------------------------------------------
	initial begin
		int i;
		int s;
		int c;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (i = 0; i < 5; i++) chk_rd(m_addr[i], 8'h00);
		chk_rd(7'h3b, 8'h10);
		for (i = 0; i < 5; i++) begin
			wr(m_addr[i], 8'hff);
			chk_rd(m_addr[i], m_val[i]);
			wr(m_addr[i], 8'h00);
		end
		wr(7'h20, 8'hff);
		chk_rd(7'h20, 8'h00);
		// Gyro only, watermark 3, stop mode
		wr(7'h06, 8'h03);
		wr(7'h08, 8'h08);
		wr(7'h0a, 8'h09);
		model.fire(1'b0, 16'h1000);
		chk_rd(7'h3a, 8'h03);
		chk_rd(7'h3b, 8'h80);
		`CHK(int1_pin, 1'b0)
		for (i = 0; i < 3; i++) pop_chk(wv(16'h1000, i));
		chk_rd(7'h3b, 8'h10);
		// Decimation codes of both sensor sets, other set undecimated
		for (s = 0; s < 2; s++) begin
			for (c = 1; c < 8; c++) begin
				clear_buf();
				wr(7'h08, (s == 1) ? {5'b00001, 3'(c)} : {2'b00, 3'(c), 3'b001});
				wr(7'h0a, 8'h09);
				repeat (fac[c] + 1) model.fire(1'b0, 16'h2000);
				chk_rd(7'h3a, 8'(3 * (fac[c] + 1) + 6));
			end
		end
		// Third set, then third set decimated by 2
		clear_buf();
		wr(7'h07, 8'h80);
		wr(7'h08, 8'h00);
		wr(7'h09, 8'h08);
		wr(7'h0a, 8'h09);
		model.fire(1'b0, 16'h3000);
		for (i = 6; i < 9; i++) pop_chk(wv(16'h3000, i));
		clear_buf();
		wr(7'h07, 8'h80);
		wr(7'h08, 8'h08);
		wr(7'h09, 8'h10);
		wr(7'h0a, 8'h09);
		repeat (3) model.fire(1'b0, 16'h3100);
		chk_rd(7'h3a, 8'h0f);
		// Step-triggered storing ignores data-ready
		clear_buf();
		wr(7'h07, 8'h40);
		wr(7'h0a, 8'h09);
		model.fire(1'b0, 16'h4000);
		chk_rd(7'h3a, 8'h00);
		model.fire(1'b1, 16'h4000);
		chk_rd(7'h3a, 8'h03);
		// High bytes only
		clear_buf();
		wr(7'h08, 8'h09);
		wr(7'h09, 8'h40);
		wr(7'h0a, 8'h09);
		model.fire(1'b0, 16'h5a10);
		pop_chk({hb(16'h5a10, 0), hb(16'h5a10, 1)});
		pop_chk({hb(16'h5a10, 2), hb(16'h5a10, 3)});
		pop_chk({hb(16'h5a10, 4), hb(16'h5a10, 5)});
		chk_rd(7'h3b, 8'h10);
		// Rate off, rate out of range and reserved modes store nothing
		for (i = 0; i < 5; i++) begin
			clear_buf();
			wr(7'h08, 8'h08);
			wr(7'h0a, off_cfg[i]);
			model.fire(1'b0, 16'h6000);
			chk_rd(7'h3b, 8'h10);
		end
		// Bypass until trigger drops, then continuous
		clear_buf();
		model.set_trig(1'b1);
		wr(7'h0a, 8'h0c);
		model.fire(1'b0, 16'h7000);
		chk_rd(7'h3b, 8'h10);
		model.set_trig(1'b0);
		repeat (5) @(posedge clk_sys);
		model.fire(1'b0, 16'h7000);
		chk_rd(7'h3a, 8'h03);
		// Depth limited to watermark 6 in stop mode
		clear_buf();
		wr(7'h06, 8'h06);
		@(posedge clk_sys);
		limit_depth_to_watermark <= 1'b1;
		wr(7'h0a, 8'h09);
		repeat (3) model.fire(1'b0, 16'h7100);
		chk_rd(7'h3a, 8'h00);
		chk_rd(7'h3b, 8'ha0);
		`CHK(int1_pin, 1'b1)
		`CHK(int2_pin, 1'b0)
		pop_chk(wv(16'h7100, 0));
		@(posedge clk_sys);
		limit_depth_to_watermark <= 1'b0;
		// Continuous fill to 4095 words, then overwrite
		clear_buf();
		wr(7'h06, 8'hff);
		wr(7'h07, 8'h0f);
		wr(7'h0a, 8'h0e);
		repeat (1365) model.fire(1'b0, 16'h0100);
		chk_rd(7'h3a, 8'hff);
		chk_rd(7'h3b, 8'h8f);
		`CHK(int1_pin, 1'b0)
		model.fire(1'b0, 16'h0100);
		chk_rd(7'h3a, 8'h00);
		chk_rd(7'h3b, 8'he0);
		`CHK(int1_pin, 1'b1)
		`CHK(int2_pin, 1'b1)
		pop_chk(wv(16'h0100, 2));
		clear_buf();
		chk_rd(7'h3b, 8'h10);
		wrap_up();
	end
endmodule

`default_nettype wire
